//--- asp_top.sv
// amplifier power sync sequencer, burst supply measurement and gain correction, apb registers
// assumes converter results arrive on conv_valid_i after each sample trigger, same clock
`timescale 1ns/10ps

module asp_top (
	// clock and reset
	input wire logic ref_clk_i,
	input wire logic rst_i,
	// apb slave
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// converter side
	input wire logic convert_start_i,
	input wire logic conv_valid_i,
	input wire logic [15:0] conv_data_i,
	output logic sample_trigger_o,
	output logic ref_sel_o,
	output logic [1:0] input_channel_select_o,
	output logic data_format_o,
	// results
	output logic result_valid_o,
	output logic [15:0] result_o,
	// pins
	output logic amp_enable_out_o,
	output logic general_output_a_o,
	output logic general_output_b_o
);

	asp_pkg::asp_cfg_t cfg_r;
	asp_pkg::asp_state_t state_r;
	logic [15:0] pwr_delay_r;
	logic [15:0] delay_cnt_r;
	logic [15:0] supply_gain_correction_r;
	logic corr_done_r;
	logic ready_r;
	logic start_d_r;

	// apb decode
	wire apb_access = psel & penable & pready;
	wire apb_wr = apb_access & pwrite;
	wire sel_cfg = (paddr == asp_pkg::ASP_OFS_CONFIG);
	wire sel_dly = (paddr == asp_pkg::ASP_OFS_PWR_DELAY);
	wire sel_corr = (paddr == asp_pkg::ASP_OFS_GAIN_CORR);
	wire sel_st = (paddr == asp_pkg::ASP_OFS_STATUS);
	wire sel_res = (paddr == asp_pkg::ASP_OFS_RESULT);
	wire mapped = sel_cfg | sel_dly | sel_corr | sel_st | sel_res;
	wire wr_cfg = apb_wr & sel_cfg;
	wire wr_dly = apb_wr & sel_dly;
	wire clr_done = apb_wr & sel_st & pwdata[asp_pkg::ASP_ST_DONE_BIT];
	wire busy = (state_r != asp_pkg::ASP_IDLE);
	wire [31:0] status_word = {29'h0000_0000, ready_r, corr_done_r, busy};
	wire [31:0] rd_data = sel_cfg ? {16'h0000, cfg_r} :
		sel_dly ? {16'h0000, pwr_delay_r} :
		sel_corr ? {16'h0000, supply_gain_correction_r} :
		sel_st ? status_word :
		sel_res ? {16'h0000, result_o} : 32'h0000_0000;

	// burst unit wiring
	logic avg_last;
	logic avg_valid;
	logic [15:0] avg_data;

	// sequencer decode
	wire burst = (cfg_r.conv_mode == asp_pkg::ASP_MODE_BURST_AVG);
	wire start_edge = convert_start_i & ~start_d_r & ~busy;
	wire [16:0] delay_next = {1'b0, delay_cnt_r} + 17'h0_0001;
	wire delay_done = (delay_next >= {1'b0, pwr_delay_r});
	wire in_wait_valid = (state_r == asp_pkg::ASP_WAIT) & conv_valid_i;
	wire burst_more = in_wait_valid & burst & ~avg_last;
	wire sample_go = ((state_r == asp_pkg::ASP_POWER) & delay_done) | burst_more;

	// result path: single conversions direct, bursts via mean
	wire single_load = in_wait_valid & ~burst;
	wire res_load = single_load | avg_valid;
	wire [15:0] code_in = avg_valid ? avg_data : conv_data_i;
	wire [31:0] product = code_in * supply_gain_correction_r;
	wire [15:0] scaled = product[31] ? 16'hFFFF : product[30:15];
	wire [15:0] res_nxt = cfg_r.scale_en ? scaled : code_in;
	// correction factor equals mean half-supply burst code, loaded whichever reference ref_sel selects
	wire corr_load = avg_valid & (cfg_r.input_channel_select == asp_pkg::ASP_CH_SUPPLY_HALF);

	// general output selection
	wire [2:0] fn_a = cfg_r.output_a_function;
	wire [2:0] fn_b = cfg_r.output_b_function;
	wire out_a_nxt = (fn_a == asp_pkg::ASP_FN_AMP_EN) ? amp_enable_out_o :
		(fn_a == asp_pkg::ASP_FN_READY) ? ready_r :
		(fn_a == asp_pkg::ASP_FN_HIGH);
	wire out_b_nxt = (fn_b == asp_pkg::ASP_FN_AMP_EN) ? amp_enable_out_o :
		(fn_b == asp_pkg::ASP_FN_READY) ? ready_r :
		(fn_b == asp_pkg::ASP_FN_HIGH);

	asp_burst_avg u_avg (
		.ref_clk_i(ref_clk_i),
		.rst_i(rst_i),
		.clear_i(start_edge),
		.log2_i(cfg_r.avg_log2),
		.sample_i(in_wait_valid & burst),
		.data_i(conv_data_i),
		.last_o(avg_last),
		.avg_valid_o(avg_valid),
		.avg_o(avg_data)
	);

	// apb handshake, one wait state so prdata can be a flop
	always_ff @(posedge ref_clk_i or posedge rst_i) begin
		if (rst_i) begin
			pready <= 1'b0;
			pslverr <= 1'b0;
			prdata <= 32'h0000_0000;
		end else begin
			pready <= psel & penable & ~pready;
			pslverr <= psel & penable & ~pready & ~mapped;
			prdata <= (psel & penable & ~pready & ~pwrite) ? rd_data : 32'h0000_0000;
		end
	end

	always_ff @(posedge ref_clk_i or posedge rst_i) begin
		if (rst_i) begin
			cfg_r <= asp_pkg::ASP_CONFIG_RST;
			pwr_delay_r <= asp_pkg::ASP_PWR_DELAY_RST;
		end else begin
			if (wr_cfg) cfg_r <= pwdata[15:0];
			if (wr_dly) pwr_delay_r <= pwdata[15:0];
		end
	end

	// selection outputs follow config directly
	assign ref_sel_o = cfg_r.ref_sel;
	assign input_channel_select_o = cfg_r.input_channel_select;
	assign data_format_o = cfg_r.data_format;

	always_ff @(posedge ref_clk_i or posedge rst_i) begin
		if (rst_i) begin
			state_r <= asp_pkg::ASP_IDLE;
			delay_cnt_r <= 16'h0000;
			amp_enable_out_o <= 1'b0;
			sample_trigger_o <= 1'b0;
			start_d_r <= 1'b0;
		end else begin
			start_d_r <= convert_start_i;
			sample_trigger_o <= sample_go;
			case (state_r)
				asp_pkg::ASP_IDLE: begin
					delay_cnt_r <= 16'h0000;
					if (start_edge) begin
						state_r <= asp_pkg::ASP_POWER;
						amp_enable_out_o <= 1'b1;
					end
				end
				asp_pkg::ASP_POWER: begin
					delay_cnt_r <= delay_next[15:0];
					if (delay_done) begin
						state_r <= asp_pkg::ASP_WAIT;
						amp_enable_out_o <= 1'b0;
					end
				end
				asp_pkg::ASP_WAIT: begin
					if (in_wait_valid & ~burst_more) state_r <= asp_pkg::ASP_IDLE;
				end
				default: begin
					state_r <= asp_pkg::ASP_IDLE;
					amp_enable_out_o <= 1'b0;
				end
			endcase
		end
	end

	always_ff @(posedge ref_clk_i or posedge rst_i) begin
		if (rst_i) begin
			supply_gain_correction_r <= asp_pkg::ASP_GAIN_UNITY;
			result_o <= 16'h0000;
			result_valid_o <= 1'b0;
		end else begin
			result_valid_o <= res_load;
			if (res_load) result_o <= res_nxt;
			if (corr_load) supply_gain_correction_r <= avg_data;
		end
	end

	// sticky flags, a set in the clearing cycle wins
	always_ff @(posedge ref_clk_i or posedge rst_i) begin
		if (rst_i) begin
			corr_done_r <= 1'b0;
			ready_r <= 1'b0;
		end else begin
			corr_done_r <= corr_load | (corr_done_r & ~clr_done);
			ready_r <= res_load | (ready_r & ~start_edge);
		end
	end

	always_ff @(posedge ref_clk_i or posedge rst_i) begin
		if (rst_i) begin
			general_output_a_o <= 1'b0;
			general_output_b_o <= 1'b0;
		end else begin
			general_output_a_o <= out_a_nxt;
			general_output_b_o <= out_b_nxt;
		end
	end

	// checks
	default clocking cb @(posedge ref_clk_i); endclocking
	default disable iff (rst_i);

	sequence s_power_start;
		start_edge ##1 (state_r == asp_pkg::ASP_POWER);
	endsequence
	sequence s_power_end;
		(state_r == asp_pkg::ASP_POWER) && delay_done;
	endsequence

	property p_amp_rise;
		start_edge |=> amp_enable_out_o && !sample_trigger_o;
	endproperty
	a_amp_rise: assert property (p_amp_rise) else $error("amp enable not raised after start edge");

	property p_hold_sample;
		s_power_start |-> !sample_trigger_o && (delay_cnt_r == 16'h0000);
	endproperty
	a_hold_sample: assert property (p_hold_sample) else $error("sample issued before power-on delay");

	property p_no_early;
		(state_r == asp_pkg::ASP_POWER) && !delay_done |=> !sample_trigger_o && amp_enable_out_o;
	endproperty
	a_no_early: assert property (p_no_early) else $error("sampling before delay elapsed");

	property p_amp_fall;
		s_power_end |=> sample_trigger_o && !amp_enable_out_o;
	endproperty
	a_amp_fall: assert property (p_amp_fall) else $error("amp enable not dropped at sampling");

	property p_route_a;
		(fn_a == asp_pkg::ASP_FN_AMP_EN) |=> general_output_a_o == $past(amp_enable_out_o);
	endproperty
	a_route_a: assert property (p_route_a) else $error("output a not following amp enable");

	property p_ref_sel;
		wr_cfg |=> ref_sel_o == $past(pwdata[0]);
	endproperty
	a_ref_sel: assert property (p_ref_sel) else $error("reference select not applied");

	property p_chan_sel;
		wr_cfg |=> input_channel_select_o == $past(pwdata[3:2]);
	endproperty
	a_chan_sel: assert property (p_chan_sel) else $error("channel select not applied");

	property p_burst_chain;
		burst_more |=> sample_trigger_o && (state_r == asp_pkg::ASP_WAIT);
	endproperty
	a_burst_chain: assert property (p_burst_chain) else $error("burst sample not chained");

	property p_corr_load;
		corr_load |=> supply_gain_correction_r == $past(avg_data) && corr_done_r;
	endproperty
	a_corr_load: assert property (p_corr_load) else $error("correction factor not loaded");

	property p_ready_a;
		(fn_a == asp_pkg::ASP_FN_READY) |=> general_output_a_o == $past(ready_r);
	endproperty
	a_ready_a: assert property (p_ready_a) else $error("ready not on output a");

	property p_static_b;
		(fn_b == asp_pkg::ASP_FN_HIGH) |=> general_output_b_o;
	endproperty
	a_static_b: assert property (p_static_b) else $error("output b not driven high");

	property p_low_b;
		(fn_b == asp_pkg::ASP_FN_LOW) |=> !general_output_b_o;
	endproperty
	a_low_b: assert property (p_low_b) else $error("output b not driven low");

	property p_scale;
		res_load && cfg_r.scale_en |=> result_valid_o && result_o == $past(scaled);
	endproperty
	a_scale: assert property (p_scale) else $error("result not scaled by correction");

	property p_corr_hold;
		!corr_load |=> $stable(supply_gain_correction_r);
	endproperty
	a_corr_hold: assert property (p_corr_hold) else $error("correction changed without burst");

endmodule : asp_top

//--- asp_pkg.sv
// constants, field layouts and types for the amplifier sync and supply reference scaling block
// assumes a single 25 MHz clock domain and an apb master for configuration
package asp_pkg;

	// register byte offsets
	localparam logic [7:0] ASP_OFS_CONFIG = 8'h00;
	localparam logic [7:0] ASP_OFS_PWR_DELAY = 8'h04;
	localparam logic [7:0] ASP_OFS_GAIN_CORR = 8'h08;
	localparam logic [7:0] ASP_OFS_STATUS = 8'h0C;
	localparam logic [7:0] ASP_OFS_RESULT = 8'h10;

	// status field positions
	localparam int ASP_ST_BUSY_BIT = 0;
	localparam int ASP_ST_DONE_BIT = 1;
	localparam int ASP_ST_READY_BIT = 2;

	// reference and channel selection codes
	localparam logic ASP_REF_PIN = 1'b0;
	localparam logic ASP_REF_SUPPLY = 1'b1;
	localparam logic [1:0] ASP_CH_DIFF = 2'b00;
	localparam logic [1:0] ASP_CH_SUPPLY_HALF = 2'b10;

	// conversion mode codes
	localparam logic [1:0] ASP_MODE_SAMPLE = 2'b00;
	localparam logic [1:0] ASP_MODE_BURST_AVG = 2'b10;

	// general output function codes
	localparam logic [2:0] ASP_FN_OFF = 3'b000;
	localparam logic [2:0] ASP_FN_AMP_EN = 3'b001;
	localparam logic [2:0] ASP_FN_READY = 3'b010;
	localparam logic [2:0] ASP_FN_LOW = 3'b011;
	localparam logic [2:0] ASP_FN_HIGH = 3'b110;

	// reset values
	localparam logic [15:0] ASP_CONFIG_RST = 16'h0000;
	localparam logic [15:0] ASP_PWR_DELAY_RST = 16'h0019;
	localparam logic [15:0] ASP_GAIN_UNITY = 16'h8000;

	// configuration word, msb first
	typedef struct packed {
		logic [2:0] avg_log2;
		logic [2:0] output_b_function;
		logic [2:0] output_a_function;
		logic scale_en;
		logic [1:0] conv_mode;
		logic [1:0] input_channel_select;
		logic data_format;
		logic ref_sel;
	} asp_cfg_t;

	// sequencer states
	typedef enum logic [1:0] {
		ASP_IDLE,
		ASP_POWER,
		ASP_WAIT
	} asp_state_t;

endpackage : asp_pkg

//--- asp_burst_avg.sv
// burst accumulator: sums 2^n converter results and presents their mean
// assumes clear_i precedes each burst and sample_i is a one-cycle pulse per result
`timescale 1ns/10ps
module asp_burst_avg (
	// clock and reset
	input wire logic ref_clk_i,
	input wire logic rst_i,
	// control
	input wire logic clear_i,
	input wire logic [2:0] log2_i,
	// samples in
	input wire logic sample_i,
	input wire logic [15:0] data_i,
	// averaged result
	output logic last_o,
	output logic avg_valid_o,
	output logic [15:0] avg_o
);

	logic [22:0] acc_r;
	logic [7:0] cnt_r;
	logic [22:0] sum_nxt;
	logic [22:0] mean_nxt;
	logic [7:0] target;

	// mean by shift, so no divider is needed; length is a power of two
	assign target = 8'((9'h001 << log2_i) - 9'h001);
	assign last_o = (cnt_r == target);
	assign sum_nxt = acc_r + {7'h00, data_i};
	assign mean_nxt = sum_nxt >> log2_i;

	// accumulate one burst
	always_ff @(posedge ref_clk_i or posedge rst_i) begin
		if (rst_i) begin
			acc_r <= '0;
			cnt_r <= '0;
			avg_valid_o <= 1'b0;
			avg_o <= 16'h0000;
		end else begin
			avg_valid_o <= 1'b0;
			if (clear_i) begin
				acc_r <= '0;
				cnt_r <= '0;
			end else if (sample_i) begin
				acc_r <= last_o ? '0 : sum_nxt;
				cnt_r <= last_o ? 8'h00 : cnt_r + 8'h01;
				if (last_o) begin
					avg_valid_o <= 1'b1;
					avg_o <= mean_nxt[15:0];
				end
			end
		end
	end

endmodule : asp_burst_avg

//--- asp_conv_model.sv
// converter stand-in: returns a result two cycles after each sample trigger
// assumes the clock and reset of asp_top; data is scrambled outside valid
`timescale 1ns/10ps
module asp_conv_model (
	// clock and reset
	input wire logic ref_clk_i,
	input wire logic rst_i,
	// from the design
	input wire logic sample_trigger_i,
	// bench controls
	input wire logic [15:0] code_i,
	input wire logic vary_i,
	// result out
	output logic conv_valid_o,
	output logic [15:0] conv_data_o
);
	logic pend_r;
	logic [1:0] cnt_r;

	// fixed latency; data inverted after valid so a stale code never passes
	always_ff @(posedge ref_clk_i or posedge rst_i) begin
		if (rst_i) begin
			pend_r <= 1'b0;
			cnt_r <= 2'h0;
			conv_valid_o <= 1'b0;
			conv_data_o <= 16'h0000;
		end else begin
			pend_r <= sample_trigger_i;
			conv_valid_o <= pend_r;
			if (pend_r) begin
				conv_data_o <= code_i + (vary_i ? {14'h0000, cnt_r} : 16'h0000);
				cnt_r <= cnt_r + 2'h1;
			end else if (conv_valid_o) begin
				conv_data_o <= ~conv_data_o;
			end
		end
	end
endmodule : asp_conv_model

//--- asp_top_tb_top.sv
// self-checking bench for asp_top: registers, sequencer timing, burst correction, scaling
// assumes asp_conv_model answers each sample trigger two cycles later
`timescale 1ns/10ps
module asp_top_tb_top;
	logic ref_clk_i = 1'b0, rst_i = 1'b1, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
	logic convert_start_i = 1'b0, vary = 1'b0, err, amp_prev = 1'b0, amp_at_trig, gpa_seen;
	logic [7:0] paddr = 8'h00;
	logic [31:0] pwdata = 32'h0000_0000, prdata, rd;
	logic [15:0] code = 16'h0000, conv_data_i, result_o;
	logic pready, pslverr, conv_valid_i, sample_trigger_o, ref_sel_o, data_format_o, result_valid_o;
	logic amp_enable_out_o, general_output_a_o, general_output_b_o;
	logic [1:0] input_channel_select_o;
	int bad_count = 0, cmp_count = 0, trig_cnt = 0, cyc = 0, t_amp = 0, t_trig = 0, s, tc, n;
	// config word beside {ref_sel, data_format, channel, output b}
	logic [20:0] rows [4] = '{21'h3_0105, 21'h1_8030, 21'h0_00CA, 21'h3_81B6};

	asp_top uut (.ref_clk_i(ref_clk_i), .rst_i(rst_i), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
		.convert_start_i(convert_start_i), .conv_valid_i(conv_valid_i), .conv_data_i(conv_data_i),
		.sample_trigger_o(sample_trigger_o), .ref_sel_o(ref_sel_o),
		.input_channel_select_o(input_channel_select_o), .data_format_o(data_format_o),
		.result_valid_o(result_valid_o), .result_o(result_o), .amp_enable_out_o(amp_enable_out_o),
		.general_output_a_o(general_output_a_o), .general_output_b_o(general_output_b_o));
	asp_conv_model mdl (.ref_clk_i(ref_clk_i), .rst_i(rst_i), .sample_trigger_i(sample_trigger_o),
		.code_i(code), .vary_i(vary), .conv_valid_o(conv_valid_i), .conv_data_o(conv_data_i));

	// clock and watchdog; the run needs well under 4000 cycles
	initial forever #20 ref_clk_i = ~ref_clk_i;
	initial begin
		#(40 * 40000);
		bad_count++;
		end_of_test();
	end

	// edge-sampled timestamps of the sequencer outputs
	always @(posedge ref_clk_i) begin
		cyc++;
		if (sample_trigger_o === 1'b1) begin
			trig_cnt++;
			t_trig = cyc;
			amp_at_trig = amp_enable_out_o;
		end
		if (amp_enable_out_o === 1'b1 && amp_prev !== 1'b1) t_amp = cyc;
		amp_prev = amp_enable_out_o;
		if (general_output_a_o === 1'b1) gpa_seen = 1'b1;
	end

	task end_of_test();
		$display("compares %0d mismatches %0d", cmp_count, bad_count);
		if (bad_count == 0 && cmp_count > 0) $display("NO MISMATCHES");
		else $display("MISMATCHES SEEN");
		$finish;
	endtask : end_of_test

	task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		cmp_count++;
		if (g !== e) begin
			bad_count++;
			$display("[ERR] %s expected %h seen %h", nm, e, g);
		end
	endtask : chk

	// one apb transfer; request held until pready is sampled high
	task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		int k;
		@(posedge ref_clk_i);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge ref_clk_i);
		penable <= 1'b1;
		k = 0;
		do begin
			@(posedge ref_clk_i);
			k++;
		end while (pready !== 1'b1 && k < 16);
		if (k == 16) bad_count++;
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask : apb

	task rchk(input logic [7:0] a, input logic [31:0] e, input string nm);
		apb(1'b0, a, 32'h0000_0000);
		chk(nm, e, rd);
	endtask : rchk

	// sample-mode conversion with a second start edge while busy
	task convert(input logic [15:0] c, input int d, input logic [15:0] e);
		tc = trig_cnt;
		@(posedge ref_clk_i);
		code <= c;
		convert_start_i <= 1'b1;
		#1 s = cyc;
		repeat (2) @(posedge ref_clk_i);
		convert_start_i <= 1'b0;
		@(posedge ref_clk_i);
		convert_start_i <= 1'b1;
		n = 0;
		do begin
			@(posedge ref_clk_i);
			n++;
		end while (result_valid_o !== 1'b1 && n < 200);
		chk("result", e, result_o);
		chk("amp lead", 2, t_amp - s);
		chk("trigger delay", d, t_trig - t_amp);
		chk("amp at trigger", 1'b0, amp_at_trig);
		repeat (8) @(posedge ref_clk_i);
		chk("triggers", 1, trig_cnt - tc);
		convert_start_i <= 1'b0;
	endtask : convert

	// calculation burst: plain status polls, since busy and ready bits move while waiting
	task calib(input logic [15:0] c, input logic v);
		tc = trig_cnt;
		@(posedge ref_clk_i);
		vary <= v;
		code <= c;
		convert_start_i <= 1'b1;
		n = 0;
		do begin
			apb(1'b0, asp_pkg::ASP_OFS_STATUS, 32'h0000_0000);
			n++;
		end while (rd[1] !== 1'b1 && n < 40);
		chk("corr done", 1'b1, rd[1]);
		chk("burst triggers", 4, trig_cnt - tc);
	endtask : calib

	// reset, table of selections, then hand-written sequences
	initial begin
		repeat (12) @(posedge ref_clk_i);
		rst_i <= 1'b0;
		rchk(asp_pkg::ASP_OFS_CONFIG, 32'h0000_0000, "config reset");
		rchk(asp_pkg::ASP_OFS_PWR_DELAY, 32'h0000_0019, "delay reset");
		rchk(asp_pkg::ASP_OFS_GAIN_CORR, 32'h0000_8000, "corr reset");
		rchk(8'h20, 32'h0000_0000, "unmapped data");
		chk("unmapped err", 1'b1, err);
		apb(1'b1, asp_pkg::ASP_OFS_GAIN_CORR, 32'h0000_1234);
		rchk(asp_pkg::ASP_OFS_GAIN_CORR, 32'h0000_8000, "corr read only");
		for (int i = 0; i < 4; i++) begin
			apb(1'b1, asp_pkg::ASP_OFS_CONFIG, {16'h0000, rows[i][20:5]});
			repeat (3) @(posedge ref_clk_i);
			chk("selects", rows[i][4:0], {ref_sel_o, data_format_o, input_channel_select_o,
				general_output_b_o});
			rchk(asp_pkg::ASP_OFS_CONFIG, {16'h0000, rows[i][20:5]}, "config readback");
		end
		apb(1'b1, asp_pkg::ASP_OFS_PWR_DELAY, 32'h0000_0003);
		apb(1'b1, asp_pkg::ASP_OFS_CONFIG, 32'h0000_0080);
		gpa_seen = 1'b0;
		convert(16'h1234, 3, 16'h1234);
		chk("amp on output a", 1'b1, gpa_seen);
		// calculation phase: ref pin, half supply, burst of 4, ready on a
		apb(1'b1, asp_pkg::ASP_OFS_PWR_DELAY, 32'h0000_0002);
		apb(1'b1, asp_pkg::ASP_OFS_CONFIG, 32'h0000_4128);
		calib(16'hA000, 1'b1);
		rchk(asp_pkg::ASP_OFS_GAIN_CORR, 32'h0000_A001, "correction");
		chk("ready on a", 1'b1, general_output_a_o);
		apb(1'b1, asp_pkg::ASP_OFS_STATUS, 32'h0000_0002);
		rchk(asp_pkg::ASP_OFS_STATUS, 32'h0000_0004, "status w1c");
		// application phase: differential inputs, supply reference, scaling on
		convert_start_i <= 1'b0;
		vary <= 1'b0;
		apb(1'b1, asp_pkg::ASP_OFS_PWR_DELAY, 32'h0000_0000);
		apb(1'b1, asp_pkg::ASP_OFS_CONFIG, 32'h0000_0CC1);
		convert(16'h1000, 1, 16'h1400);
		rchk(asp_pkg::ASP_OFS_RESULT, 32'h0000_1400, "result reg");
		convert(16'hF000, 1, 16'hFFFF);
		rchk(asp_pkg::ASP_OFS_GAIN_CORR, 32'h0000_A001, "corr kept");
		// periodic recalculation: the new mean must replace the old factor
		apb(1'b1, asp_pkg::ASP_OFS_CONFIG, 32'h0000_4128);
		calib(16'h9000, 1'b0);
		rchk(asp_pkg::ASP_OFS_GAIN_CORR, 32'h0000_9000, "corr repeat");
		// second reset in mid-run
		@(posedge ref_clk_i);
		rst_i <= 1'b1;
		convert_start_i <= 1'b0;
		repeat (2) @(posedge ref_clk_i);
		rst_i <= 1'b0;
		rchk(asp_pkg::ASP_OFS_GAIN_CORR, 32'h0000_8000, "corr after reset");
		rchk(asp_pkg::ASP_OFS_CONFIG, 32'h0000_0000, "config after reset");
		end_of_test();
	end
endmodule : asp_top_tb_top
